// [shared/sso_pkg.sv]
// Package: constants, types and field layouts for the stats/options unit
package sso_pkg;

  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int unsigned NUM_IDS  = 16;
  localparam int unsigned CNT_W    = 32;
  localparam int unsigned ID_W     = 4;

  // ****************************************
  // Command codes and error codes
  // ****************************************
  localparam logic [7:0] CMD_EXT_UNIT_OPT = 8'h18;
  localparam logic [7:0] ADAPTER_BOARD_ID = 8'hFF;
  localparam logic [7:0] ERR_NONE         = 8'h00;
  localparam logic [7:0] ERR_BAD_UNIT     = 8'h02;
  localparam logic [7:0] ERR_RECONN_TMO   = 8'h1F;

  // ****************************************
  // Options structure word offsets (bytes)
  // ****************************************
  localparam logic [31:0] OPT_OFS_W0 = 32'h0000_0000;
  localparam logic [31:0] OPT_OFS_W1 = 32'h0000_0004;
  localparam logic [31:0] OPT_OFS_W2 = 32'h0000_0008;

  // Retry control bit positions
  localparam int unsigned RC_BUS_BIT = 4;
  localparam int unsigned RC_BAD_BIT = 3;
  localparam int unsigned RC_PAR_BIT = 2;
  localparam int unsigned RC_ISB_BIT = 1;
  localparam int unsigned RC_INT_BIT = 0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned TICK_MS       = 100;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;

  // ****************************************
  // Register map (APB byte addresses)
  // ****************************************
  localparam logic [11:0] A_TOTAL   = 12'h000;
  localparam logic [11:0] A_BADST   = 12'h004;
  localparam logic [11:0] A_PARITY  = 12'h008;
  localparam logic [11:0] A_TSEL    = 12'h00C;
  localparam logic [11:0] A_CTRL    = 12'h010;
  localparam logic [11:0] A_STATUS  = 12'h014;
  localparam logic [11:0] A_UNITCFG = 12'h018;
  localparam logic [11:0] A_TGT_CMD = 12'h100;
  localparam logic [11:0] A_TGT_QF  = 12'h140;
  localparam logic [11:0] A_TGT_MQ  = 12'h180;
  localparam logic [11:0] A_TGT_END = 12'h1C0;
  localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [7:0]  cmd;
    logic [7:0]  adapter;
    logic [7:0]  am;
    logic [31:0] tag;
    logic [31:0] addr;
  } sso_pblk_t;

  typedef struct packed {
    logic [31:0] tag;
    logic [7:0]  err;
    logic        irq;
  } sso_sblk_t;

  typedef struct packed {
    logic        done;
    logic        bad_status;
    logic        parity_err;
    logic        bus_err;
    logic        queue_full;
  } sso_cmd_res_t;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_RD_W0 = 6'b000010,
    ST_RD_W1 = 6'b000100,
    ST_RD_W2 = 6'b001000,
    ST_CHECK = 6'b010000,
    ST_POST  = 6'b100000
  } sso_state_t;

endpackage

// [hdl/sso_unit.sv]
// Statistics counters and per-unit options command engine
`timescale 1ns/1ps
// ****************************************
// Behaviour
// - Count all processed commands, clear on reset
// - Count non-Good completion statuses
// - Count detected SCSI parity errors
// - Count selections while acting as target
// - Per-target command count, own ID zero
// - Per-target Queue Full count
// - Per-target peak outstanding queue depth
// - Code 18H with adapter FFH selects options
// - Copy command tag into status block
// - Drive fetch address modifier from block
// - Options words at 00H, 04H, 08H
// - Unit ID equal own ID gives 02H
// - Reconnect timer 100 ms steps, pulses o_reconn_tmo
// - Zero disconnect time-out disables timer
// - Retries bounded by limit, count cleared when no retry
// - Zero retry limit means no retries
// - Retry control bit layout, 7..5 zero
// - Per-retry status block only when enabled
// - Retry interrupt bit unused, status irq always zero
// - Parity retry only when enabled
// - Bad-status retry only when enabled
// - Bus-error retry only when enabled
// - Counters clear on reset or wipe only
// ****************************************
module sso_unit #(
  parameter int unsigned TICK_CYC = sso_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_srst,
  // APB slave
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [11:0]          i_paddr,
  input  wire logic [31:0]          i_pwdata,
  output logic                      o_pready,
  output logic [31:0]               o_prdata,
  output logic                      o_pslverr,
  // Command processing events
  input  wire logic                 i_cmd_valid,
  input  wire sso_pkg::sso_pblk_t   i_pblk,
  input  wire logic [3:0]           i_cmd_target,
  input  wire logic                 i_cmd_to_target,
  input  wire sso_pkg::sso_cmd_res_t i_res,
  input  wire logic [3:0]           i_res_target,
  input  wire logic                 i_tgt_selected,
  input  wire logic [7:0]           i_queue_depth,
  input  wire logic                 i_disc_wait,
  input  wire logic                 i_reconnect,
  // Memory fetch port
  output logic                      o_mem_req,
  output logic [31:0]               o_mem_addr,
  output logic [7:0]                o_mem_am,
  input  wire logic                 i_mem_ack,
  input  wire logic [31:0]          i_mem_rdata,
  // Status block, retry decisions and reconnect time-out
  output sso_pkg::sso_sblk_t        o_sblk,
  output logic                      o_sblk_valid,
  output logic                      o_retry,
  output logic                      o_retry_sblk,
  output logic                      o_reconn_tmo
);
  import sso_pkg::*;

  // ****************************************
  // Counter storage
  // ****************************************
  logic [CNT_W-1:0] total_q, total_d;
  logic [CNT_W-1:0] badst_q, badst_d;
  logic [CNT_W-1:0] par_q, par_d;
  logic [CNT_W-1:0] tsel_q, tsel_d;
  logic [CNT_W-1:0] tcmd_q [NUM_IDS];
  logic [CNT_W-1:0] tcmd_d [NUM_IDS];
  logic [CNT_W-1:0] tqf_q  [NUM_IDS];
  logic [CNT_W-1:0] tqf_d  [NUM_IDS];
  logic [7:0]       tmq_q  [NUM_IDS];
  logic [7:0]       tmq_d  [NUM_IDS];
  logic [ID_W-1:0]  own_id_q, own_id_d;
  logic             wipe;
  logic             apb_wr;

  // Saturating increment keeps long runs from wrapping to small values
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  // Writes land only at the edge where the master sees pready high
  assign apb_wr = i_psel && i_penable && i_pwrite && rdy_q;
  assign wipe   = apb_wr && (i_paddr == A_CTRL) && i_pwdata[0];

  // Global counters next state
  always_comb begin
    total_d  = total_q;
    badst_d  = badst_q;
    par_d    = par_q;
    tsel_d   = tsel_q;
    own_id_d = own_id_q;
    if (apb_wr && (i_paddr == A_CTRL)) begin
      own_id_d = i_pwdata[11:8];
    end
    if (wipe) begin
      total_d = '0;
      badst_d = '0;
      par_d   = '0;
      tsel_d  = '0;
    end else begin
      if (i_cmd_valid) total_d = sat_inc(total_q);
      if (i_res.done && i_res.bad_status) begin
        badst_d = sat_inc(badst_q);
      end
      if (i_res.done && i_res.parity_err) par_d = sat_inc(par_q);
      if (i_tgt_selected) tsel_d = sat_inc(tsel_q);
    end
  end

  // Per-target counters, one slice per SCSI ID
  for (genvar g = 0; g < NUM_IDS; g++) begin : g_tgt
    always_comb begin
      tcmd_d[g] = tcmd_q[g];
      tqf_d[g]  = tqf_q[g];
      tmq_d[g]  = tmq_q[g];
      if (wipe) begin
        tcmd_d[g] = '0;
        tqf_d[g]  = '0;
        tmq_d[g]  = '0;
      end else begin
        if (i_cmd_valid && i_cmd_to_target && i_cmd_target == g
            && own_id_q != g) begin
          tcmd_d[g] = sat_inc(tcmd_q[g]);
        end
        if (i_res.done && i_res.queue_full && i_res_target == g) begin
          tqf_d[g] = sat_inc(tqf_q[g]);
        end
        if (i_res_target == g && i_queue_depth > tmq_q[g]) begin
          tmq_d[g] = i_queue_depth;
        end
      end
    end
    always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
        tcmd_q[g] <= '0;
        tqf_q[g]  <= '0;
        tmq_q[g]  <= '0;
      end else begin
        tcmd_q[g] <= tcmd_d[g];
        tqf_q[g]  <= tqf_d[g];
        tmq_q[g]  <= tmq_d[g];
      end
    end
  end

  // Global counter registers
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      total_q  <= '0;
      badst_q  <= '0;
      par_q    <= '0;
      tsel_q   <= '0;
      own_id_q <= '0;
    end else begin
      total_q  <= total_d;
      badst_q  <= badst_d;
      par_q    <= par_d;
      tsel_q   <= tsel_d;
      own_id_q <= own_id_d;
    end
  end

  // ****************************************
  // Options fetch engine
  // ****************************************
  sso_state_t   st_q, st_d;
  logic [31:0]  tag_q, tag_d, base_q, base_d;
  logic [7:0]   am_q, am_d;
  logic [15:0]  dto_q, dto_d;
  logic [3:0]   uid_q, uid_d;
  logic [7:0]   rctl_q, rctl_d, rlim_q, rlim_d;
  logic         req_q, req_d;
  logic [31:0]  maddr_q, maddr_d;
  sso_sblk_t    sb_q, sb_d;
  logic         sbv_q, sbv_d;
  logic         hit;

  assign hit = i_cmd_valid && (i_pblk.cmd == CMD_EXT_UNIT_OPT)
               && (i_pblk.adapter == ADAPTER_BOARD_ID);

  // Fetch sequence next state
  always_comb begin
    st_d    = st_q;
    tag_d   = tag_q;
    base_d  = base_q;
    am_d    = am_q;
    dto_d   = dto_q;
    uid_d   = uid_q;
    rctl_d  = rctl_q;
    rlim_d  = rlim_q;
    req_d   = req_q;
    maddr_d = maddr_q;
    sb_d    = sb_q;
    sbv_d   = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (hit) begin
          tag_d   = i_pblk.tag;
          base_d  = i_pblk.addr;
          am_d    = i_pblk.am;
          maddr_d = i_pblk.addr + OPT_OFS_W0;
          req_d   = 1'b1;
          st_d    = ST_RD_W0;
        end
      end
      ST_RD_W0: begin
        if (i_mem_ack) begin
          dto_d   = i_mem_rdata[31:16];
          uid_d   = i_mem_rdata[11:8];
          maddr_d = base_q + OPT_OFS_W1;
          st_d    = ST_RD_W1;
        end
      end
      ST_RD_W1: begin
        if (i_mem_ack) begin
          rctl_d  = {3'b000, i_mem_rdata[12:8]};
          rlim_d  = i_mem_rdata[7:0];
          maddr_d = base_q + OPT_OFS_W2;
          st_d    = ST_RD_W2;
        end
      end
      ST_RD_W2: begin
        // Sense fields are handled elsewhere; only the word is consumed
        if (i_mem_ack) begin
          req_d = 1'b0;
          st_d  = ST_CHECK;
        end
      end
      ST_CHECK: begin
        sb_d.tag = tag_q;
        sb_d.irq = 1'b0;
        sb_d.err = (uid_q == own_id_q) ? ERR_BAD_UNIT : ERR_NONE;
        st_d     = ST_POST;
      end
      ST_POST: begin
        sbv_d = 1'b1;
        st_d  = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      st_q    <= ST_IDLE;
      tag_q   <= '0;
      base_q  <= '0;
      am_q    <= '0;
      dto_q   <= '0;
      uid_q   <= '0;
      rctl_q  <= '0;
      rlim_q  <= '0;
      req_q   <= 1'b0;
      maddr_q <= '0;
      sb_q    <= '0;
      sbv_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      tag_q   <= tag_d;
      base_q  <= base_d;
      am_q    <= am_d;
      dto_q   <= dto_d;
      uid_q   <= uid_d;
      rctl_q  <= rctl_d;
      rlim_q  <= rlim_d;
      req_q   <= req_d;
      maddr_q <= maddr_d;
      sb_q    <= sb_d;
      sbv_q   <= sbv_d;
    end
  end

  // ****************************************
  // Retry decision and reconnect timer
  // ****************************************
  logic [7:0]  rcnt_q, rcnt_d;
  logic        rty_q, rty_d, rsb_q, rsb_d;
  logic [31:0] tick_q, tick_d;
  logic [15:0] steps_q, steps_d;
  logic        tmo_q, tmo_d;
  logic        err_ok;

  // Each error class retries only when its own enable is set
  assign err_ok = (i_res.parity_err && rctl_q[RC_PAR_BIT])
               || (i_res.bad_status && rctl_q[RC_BAD_BIT])
               || (i_res.bus_err    && rctl_q[RC_BUS_BIT]);

  always_comb begin
    rcnt_d  = rcnt_q;
    rty_d   = 1'b0;
    rsb_d   = 1'b0;
    tick_d  = tick_q;
    steps_d = steps_q;
    tmo_d   = 1'b0;
    if (i_cmd_valid && !hit) rcnt_d = '0;
    if (i_res.done) begin
      if (err_ok && rcnt_q < rlim_q) begin
        rty_d  = 1'b1;
        rcnt_d = rcnt_q + 1'b1;
        rsb_d  = rctl_q[RC_ISB_BIT];
      end else begin
        rcnt_d = '0;
      end
    end
    // Timer idles outside a disconnect; zero limit never expires
    if (!i_disc_wait || i_reconnect || dto_q == '0) begin
      tick_d  = '0;
      steps_d = '0;
    end else if (tick_q == TICK_CYC - 1) begin
      tick_d  = '0;
      steps_d = steps_q + 1'b1;
      tmo_d   = (steps_q + 1'b1) == dto_q;
    end else begin
      tick_d = tick_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rcnt_q  <= '0;
      rty_q   <= 1'b0;
      rsb_q   <= 1'b0;
      tick_q  <= '0;
      steps_q <= '0;
      tmo_q   <= 1'b0;
    end else begin
      rcnt_q  <= rcnt_d;
      rty_q   <= rty_d;
      rsb_q   <= rsb_d;
      tick_q  <= tick_d;
      steps_q <= steps_d;
      tmo_q   <= tmo_d;
    end
  end

  // ****************************************
  // APB read path
  // ****************************************
  logic [31:0] rd_d, rd_q;
  logic        rdy_q, err_d, err_q;
  logic [3:0]  ix;
  assign ix = i_paddr[5:2];

  // Address decode; unmapped reads return zero with slave error
  always_comb begin
    rd_d  = RD_ZERO;
    err_d = 1'b0;
    if (i_paddr == A_TOTAL) rd_d = total_q;
    else if (i_paddr == A_BADST) rd_d = badst_q;
    else if (i_paddr == A_PARITY) rd_d = par_q;
    else if (i_paddr == A_TSEL) rd_d = tsel_q;
    else if (i_paddr == A_CTRL) rd_d = {20'h0_0000, own_id_q, 8'h00};
    else if (i_paddr == A_STATUS) rd_d = {26'h000_0000, st_q};
    else if (i_paddr == A_UNITCFG) rd_d = {dto_q, rctl_q, rlim_q};
    else if (i_paddr >= A_TGT_CMD && i_paddr < A_TGT_QF) rd_d = tcmd_q[ix];
    else if (i_paddr >= A_TGT_QF && i_paddr < A_TGT_MQ) rd_d = tqf_q[ix];
    else if (i_paddr >= A_TGT_MQ && i_paddr < A_TGT_END) begin
      rd_d = {24'h00_0000, tmq_q[ix]};
    end else err_d = 1'b1;
  end

  // Single wait state: ready the cycle after penable rises
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rdy_q <= 1'b0;
      rd_q  <= '0;
      err_q <= 1'b0;
    end else begin
      rdy_q <= i_psel && i_penable && !rdy_q;
      rd_q  <= rd_d;
      err_q <= err_d && i_psel && i_penable;
    end
  end

  assign o_pready     = rdy_q;
  assign o_prdata     = rd_q;
  assign o_pslverr    = err_q;
  assign o_mem_req    = req_q;
  assign o_mem_addr   = maddr_q;
  assign o_mem_am     = am_q;
  assign o_sblk       = sb_q;
  assign o_sblk_valid = sbv_q;
  assign o_retry      = rty_q;
  assign o_retry_sblk = rsb_q;
  assign o_reconn_tmo = tmo_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  a_wipe_total: assert property (wipe |=> total_q == '0)
    else $error("total not cleared by wipe");
  a_total_sat: assert property (&total_q && !wipe |=> &total_q)
    else $error("total counter wrapped");
  // One check per ID keeps the index constant inside $past
  for (genvar h = 0; h < NUM_IDS; h++) begin : g_own_chk
    a_own_id_zero: assert property (@(posedge i_clk_sys)
      disable iff (i_srst) i_cmd_valid && own_id_q == h && !wipe |=>
      tcmd_q[h] == $past(tcmd_q[h]))
      else $error("own id counter moved");
  end
  a_no_lim_retry: assert property (rlim_q == '0 |=> !rty_q)
    else $error("retry with zero limit");
  a_isb_gate: assert property (rsb_q |-> rty_q)
    else $error("retry status block without retry");
  a_bad_unit: assert property (
    st_q == ST_CHECK && uid_q == own_id_q |=> sb_q.err == ERR_BAD_UNIT)
    else $error("bad unit not flagged");
  a_tag_copy: assert property (sbv_q |-> sb_q.tag == tag_q)
    else $error("status tag mismatch");
  a_am_drive: assert property (o_mem_req |-> o_mem_am == am_q)
    else $error("address modifier not driven");
  a_tmo_off: assert property (dto_q == '0 |-> !o_reconn_tmo)
    else $error("timeout with zero limit");
endmodule

// [tb/sso_mem_model.sv]
// Memory model that holds the host-built unit options structure
`timescale 1ns/1ps
module sso_mem_model #(
  parameter logic [31:0] BASE = 32'h0000_4000
) (
  // Clock
  input  wire logic        i_clk_sys,
  // Fetch port
  input  wire logic        i_mem_req,
  input  wire logic [31:0] i_mem_addr,
  output logic             o_mem_ack,
  output logic [31:0]      o_mem_rdata,
  // Contents, pacing and offset error flag
  input  wire logic [31:0] i_w0,
  input  wire logic [31:0] i_w1,
  input  wire logic [3:0]  i_lat,
  output logic             o_bad_ofs
);
  logic [3:0]  wait_q;
  logic [31:0] ofs_q;

  // Known start so the first fetch sees a clean model
  initial begin
    o_mem_ack = 1'b0;
    o_mem_rdata = 32'h0000_0000;
    o_bad_ofs = 1'b0;
    wait_q = 4'h0;
    ofs_q = 32'h0000_0000;
  end

  // Answer after i_lat cycles; data toggles when not answering
  always @(posedge i_clk_sys) begin
    o_mem_ack <= 1'b0;
    o_mem_rdata <= ~o_mem_rdata;
    if (i_mem_req !== 1'b1) begin
      ofs_q <= 32'h0000_0000;
    end else if (o_mem_ack !== 1'b1) begin
      if (wait_q < i_lat) begin
        wait_q <= wait_q + 4'h1;
      end else begin
        wait_q <= 4'h0;
        o_mem_ack <= 1'b1;
        ofs_q <= ofs_q + 32'h0000_0004;
        if (i_mem_addr !== BASE + ofs_q) o_bad_ofs <= 1'b1;
        o_mem_rdata <= (ofs_q == 32'h0000_0000) ? i_w0 :
                       (ofs_q == 32'h0000_0004) ? i_w1 : 32'h0000_0000;
      end
    end
  end
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the statistics and unit options block
`timescale 1ns/1ps
module tb_top;
  import sso_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  localparam int          TK   = 10;
  localparam logic [31:0] BASE = 32'h0000_4000;
  logic         clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, maddr, mrdata, w0, w1, rd_v, tag_v;
  logic         cmd_valid, to_tgt, tsel, disc, mreq, mack, sblk_v;
  logic         retry, rsb, tmo, bad_ofs, err_v;
  logic [3:0]   cmd_tgt, res_tgt, lat;
  logic [7:0]   qdepth, mam, lim;
  logic [4:0]   en, rc;
  sso_pblk_t    pblk;
  sso_cmd_res_t res;
  sso_sblk_t    sblk, got;
  int           err_total, num_checks, nret, nrsb, nreq, ntmo;
  int           ncmd, nbad, npar, n;

  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  sso_unit #(.TICK_CYC(TK)) DUT (
    .i_clk_sys(clk), .i_srst(srst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_cmd_valid(cmd_valid), .i_pblk(pblk),
    .i_cmd_target(cmd_tgt), .i_cmd_to_target(to_tgt), .i_res(res),
    .i_res_target(res_tgt), .i_tgt_selected(tsel),
    .i_queue_depth(qdepth), .i_disc_wait(disc), .i_reconnect(1'b0),
    .o_mem_req(mreq), .o_mem_addr(maddr), .o_mem_am(mam),
    .i_mem_ack(mack), .i_mem_rdata(mrdata), .o_sblk(sblk),
    .o_sblk_valid(sblk_v), .o_retry(retry), .o_retry_sblk(rsb),
    .o_reconn_tmo(tmo));

  sso_mem_model #(.BASE(BASE)) MEM (
    .i_clk_sys(clk), .i_mem_req(mreq), .i_mem_addr(maddr),
    .o_mem_ack(mack), .o_mem_rdata(mrdata), .i_w0(w0), .i_w1(w1),
    .i_lat(lat), .o_bad_ofs(bad_ofs));

  // Tally high cycles; retry, rsb and tmo are one-cycle pulses, mreq holds for the whole fetch
  always @(posedge clk) begin
    if (retry === 1'b1) nret++;
    if (rsb === 1'b1) nrsb++;
    if (mreq === 1'b1) nreq++;
    if (tmo === 1'b1) ntmo++;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    num_checks++;
    if (g !== e) begin
      $display("wrong value at %0t: %s", $time, m);
      err_total++;
    end
  endtask

  // APB master: hold the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    if (pready !== 1'b1) err_total++;
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input string m);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd_v, e, m);
  endtask

  task automatic cmd(input logic [7:0] c, input logic [7:0] ad,
                     input logic [3:0] t, input logic tt);
    @(posedge clk);
    cmd_valid <= 1'b1;
    pblk <= {c, ad, 8'h3D, tag_v, BASE};
    cmd_tgt <= t;
    to_tgt <= tt;
    ncmd++;
    @(posedge clk);
    cmd_valid <= 1'b0;
    to_tgt <= 1'b0;
  endtask

  // Options command: fetch, then status block with tag and error
  task automatic opt(input logic [31:0] a, input logic [31:0] b,
                     input logic [7:0] e);
    int k;
    w0 <= a;
    w1 <= b;
    tag_v = tag_v + 32'h0000_0001;
    cmd(8'h18, 8'hFF, 4'h0, 1'b0);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (mreq !== 1'b1 && k < 20);
    if (mreq !== 1'b1) err_total++;
    chk({24'h00_0000, mam}, 32'h0000_003D, "fetch modifier");
    chk(maddr, BASE, "fetch base");
    do begin
      @(posedge clk);
      k++;
    end while (sblk_v !== 1'b1 && k < 90);
    if (sblk_v !== 1'b1) err_total++;
    got = sblk;
    chk(got.tag, tag_v, "status tag");
    chk({24'h00_0000, got.err}, {24'h00_0000, e}, "status err");
    chk({31'h0000_0000, got.irq}, 32'h0000_0000, "irq");
  endtask

  task automatic rs(input logic [3:0] t, input sso_cmd_res_t r);
    @(posedge clk);
    res <= r;
    res_tgt <= t;
    if (r.bad_status) nbad++;
    if (r.parity_err) npar++;
    @(posedge clk);
    res <= '0;
    repeat (4) @(posedge clk);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {psel, penable, pwrite, cmd_valid, to_tgt, tsel, disc} = '0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {cmd_tgt, res_tgt, lat, qdepth} = '0;
    pblk = '0;
    res = '0;
    w0 = 32'h0000_0000;
    w1 = 32'h0000_0000;
    tag_v = 32'h0000_5A00;
    srst = 1'b1;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rdc(A_TOTAL, 32'h0000_0000, "total after reset");
    rdc(A_TGT_END, RD_ZERO, "unmapped data");
    chk({31'h0000_0000, err_v}, 32'h0000_0001, "unmapped slverr");
    apb(1'b1, A_CTRL, 32'h0000_0700);
    opt(32'h0002_0700, 32'h0000_0000, ERR_BAD_UNIT);
    nreq = 0;
    cmd(8'h06, 8'hFF, 4'h0, 1'b0);
    cmd(8'h18, 8'h00, 4'h0, 1'b0);
    repeat (10) @(posedge clk);
    chk(nreq, 0, "fetch for other command");
    // Each retry class: enabled with report, no report, zero limit, off
    for (int k = 0; k < 3; k++) begin
      for (int c = 0; c < 4; c++) begin
        en = 5'h10 >> k;
        rc = (c == 3) ? (5'h1C & ~en) : en;
        if (c != 1) rc = rc | 5'h02;
        lim = (c == 2) ? 8'h00 : 8'h02;
        lat <= 4'(2 * c);
        opt(32'h0002_0300, {19'h0_0000, rc, lim}, ERR_NONE);
        nret = 0;
        nrsb = 0;
        repeat (3) rs(4'h3, {1'b1, k == 1, k == 2, k == 0, 1'b0});
        chk(nret, (c < 2) ? 2 : 0, "retries");
        chk(nrsb, (c == 0) ? 2 : 0, "retry blocks");
      end
    end
    opt(32'h0002_0300, 32'h0000_0000, ERR_NONE);
    disc <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (tmo !== 1'b1 && n < 100);
    chk(n >= 2 * TK - 2 && n <= 2 * TK + 3, 1, "reconnect time");
    disc <= 1'b0;
    opt(32'h0000_0300, 32'h0000_0000, ERR_NONE);
    ntmo = 0;
    disc <= 1'b1;
    repeat (100) @(posedge clk);
    disc <= 1'b0;
    chk(ntmo, 0, "timer disabled");
    rdc(A_TOTAL, ncmd, "total");
    rdc(A_BADST, nbad, "bad status");
    rdc(A_PARITY, npar, "parity");
    apb(1'b1, A_CTRL, 32'h0000_0701);
    rdc(A_BADST, 32'h0000_0000, "bad status wiped");
    ncmd = 0;
    nbad = 0;
    npar = 0;
    // Per-target traffic, own ID 7 and a non-target command
    cmd(8'h01, 8'h00, 4'h2, 1'b1);
    cmd(8'h01, 8'h00, 4'h2, 1'b1);
    cmd(8'h01, 8'h00, 4'h7, 1'b1);
    cmd(8'h01, 8'h00, 4'h4, 1'b0);
    rs(4'h2, 5'h18);
    rs(4'h2, 5'h14);
    repeat (2) rs(4'h9, 5'h19);
    repeat (2) begin
      @(posedge clk);
      tsel <= 1'b1;
      @(posedge clk);
      tsel <= 1'b0;
    end
    @(posedge clk);
    res_tgt <= 4'h5;
    qdepth <= 8'h03;
    @(posedge clk);
    qdepth <= 8'h07;
    @(posedge clk);
    qdepth <= 8'h02;
    @(posedge clk);
    qdepth <= 8'h00;
    rdc(A_TOTAL, ncmd, "total");
    rdc(A_BADST, nbad, "bad status");
    rdc(A_PARITY, npar, "parity");
    rdc(A_TSEL, 32'h0000_0002, "target selects");
    rdc(12'h108, 32'h0000_0002, "target 2 cmds");
    rdc(12'h11C, 32'h0000_0000, "own id cmds");
    rdc(12'h110, 32'h0000_0000, "unused id cmds");
    rdc(12'h164, 32'h0000_0002, "queue full");
    rdc(12'h194, 32'h0000_0007, "max queued");
    apb(1'b1, A_CTRL, 32'h0000_0700);
    rdc(A_TOTAL, ncmd, "kept without wipe");
    chk({31'h0000_0000, bad_ofs}, 32'h0000_0000, "fetch offsets");
    give_verdict();
  end
endmodule
